// ==== core/tmgl_map.svh ====
// Register offsets, field positions, reset values and limits of the stage
`ifndef TMGL_MAP_SVH
`define TMGL_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMGL_ADR_CTRL 8'h00
`define TMGL_ADR_GAIN0 8'h04
`define TMGL_ADR_GAIN3 8'h10
`define TMGL_ADR_KNOB 8'h14
`define TMGL_ADR_LIMTH 8'h18
`define TMGL_ADR_STAT 8'h1c
`define TMGL_ADR_RATE 8'h20
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TMGL_CTRL_LINK_LR 0
`define TMGL_CTRL_LINK_AUX 1
`define TMGL_CTRL_LIM_LR 3:2
`define TMGL_CTRL_LIM_AUX 5:4
`define TMGL_CTRL_W16 6
`define TMGL_CTRL_DOFF 7
`define TMGL_CTRL_RATE 11:8
`define TMGL_CTRL_RST 32'h0000_0400
// ----------------------------------------------------------------
// Knob register fields
// ----------------------------------------------------------------
`define TMGL_KNOB_STEP 7:0
`define TMGL_KNOB_TRK 9:8
`define TMGL_KNOB_PRESS 10
// ----------------------------------------------------------------
// Gain range in tenths of a decibel, limiter and rate limits
// ----------------------------------------------------------------
`define TMGL_GAIN_MIN 11'sh5a8
`define TMGL_GAIN_MAX 11'sh096
`define TMGL_GAIN_UNITY 11'sh000
`define TMGL_LOG2_K 12'sh441
`define TMGL_LIM_TH_RST 24'h7a0000
`define TMGL_GR_UNITY 16'h8000
`define TMGL_GR_REL 16'h0010
`define TMGL_HIGH_HZ 17'h0bbb0
`define TMGL_HI_TRACKS 4'h8
`define TMGL_HI_MEDIA 2'h2
`define TMGL_HI_DELAY_MS 5'h0f
`define TMGL_LFSR_SEED 24'h5a5a5a
`endif

// ==== core/tmgl_pkg.sv ====
// Types shared by the track master gain and limiter stage
package tmgl_pkg;
	typedef logic signed [23:0] tmgl_smp_t;
	typedef logic signed [10:0] tmgl_gain_t;
	// Four tracks: 0 left, 1 right, 2 aux_track_one, 3 aux_track_two
	typedef struct packed {
		logic valid;
		tmgl_smp_t [3:0] smp;
	} tmgl_frame_t;
	// Gains from the external fader controller, tenths of a dB
	typedef struct packed {
		tmgl_gain_t [3:0] gain;
	} tmgl_fader_t;
	// Limits imposed on the rest of the recorder at high rates
	typedef struct packed {
		logic high_rate;
		logic [3:0] max_tracks;
		logic [1:0] max_media;
		logic [4:0] max_delay_ms;
		logic input_lim_en;
		logic automix_en;
	} tmgl_restrict_t;
	// Limiter mode of a pair, as held in the limiter_mode_softkey field
	typedef enum logic [1:0] {
		TMGL_LIM_OFF = 2'h0,
		TMGL_LIM_ON = 2'h1,
		TMGL_LIM_LINKED = 2'h2
	} tmgl_lim_t;
endpackage

// ==== core/tmgl_stage.sv ====
// Track master gain, limiter and word-length stage with Wishbone slave
// What this block does
// - Four tracks, each gain -60..+15 dB, 0.1 steps
// - Linked pair shares one gain control
// - Gain applied to summed track signal
// - Knob step 0.1 dB; press restores 0 dB
// - Own limiter per track, shared threshold
// - Limiter mode set per track pair
// - Linked mode: identical reduction on both tracks
// - Independent mode: each limiter uses own track
// - Indicators: engaged, actively limiting, pair joined
// - Fader controller attached supplies all gains
// - One selected rate from eight listed
// - Pulled modes stamp own rate; codes 3, 6, 10 stamp nominal 48 or 96
// - External clock: stamp with closest rate
// - Above 48.048 kHz restrict tracks, media, features
// - Word length sixteen or twenty-four bits
// - Sixteen bits use pseudo-random dither
// - Dither off truncates low eight bits
`timescale 1ns/1ps
`default_nettype none
`include "tmgl_map.svh"
module tmgl_stage (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Summed track samples in and processed samples out
	input wire tmgl_pkg::tmgl_frame_t frame_i,
	output tmgl_pkg::tmgl_frame_t frame_o,
	// External fader controller
	input wire logic fader_attached_i,
	input wire tmgl_pkg::tmgl_fader_t fader_i,
	// External word clock status
	input wire logic ext_lock_i,
	input wire logic [16:0] ext_rate_hz_i,
	// Rate, stamp and restrictions
	output logic [16:0] run_rate_hz_o,
	output logic [16:0] stamp_rate_hz_o,
	output tmgl_pkg::tmgl_restrict_t restrict_o
);
	import tmgl_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Byte-lane merge of a bus write into a stored word
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Clamp a wide gain value into the documented range
	function automatic tmgl_gain_t gclamp(input logic signed [12:0] g);
		if (g < 13'(`TMGL_GAIN_MIN)) begin
			return `TMGL_GAIN_MIN;
		end else if (g > 13'(`TMGL_GAIN_MAX)) begin
			return `TMGL_GAIN_MAX;
		end
		return g[10:0];
	endfunction

	// Saturate a wide signed value to 24 bits
	function automatic tmgl_smp_t sat24(input logic signed [47:0] v);
		if (v > 48'sh7fffff) begin
			return 24'sh7fffff;
		end else if (v < -48'sh800000) begin
			return -24'sh800000;
		end
		return v[23:0];
	endfunction

	// Gain in tenths of a dB to a linear multiply; mantissa uses 1+f,
	// a cheap 2^f estimate that trades accuracy for no lookup table
	function automatic tmgl_smp_t gapply(input tmgl_smp_t x,
		input tmgl_gain_t g);
		logic signed [22:0] l2;
		logic signed [6:0] ip;
		logic signed [17:0] man;
		logic signed [47:0] p;
		l2 = 23'(g) * 23'(`TMGL_LOG2_K);
		ip = 7'(l2 >>> 16);
		man = {2'b01, l2[15:0]};
		p = 48'(x) * 48'(man);
		if (ip >= 0) begin
			p = p <<< ip;
		end else begin
			p = p >>> (-ip);
		end
		return sat24(p >>> 16);
	endfunction

	// Run rate in Hz for a selected rate code, pulled modes included
	function automatic logic [16:0] run_hz(input logic [3:0] c);
		case (c)
			4'h0: return 17'd32000;
			4'h1: return 17'd44100;
			4'h2, 4'h3: return 17'd47952;
			4'h4: return 17'd48000;
			4'h5, 4'h6: return 17'd48048;
			4'h7: return 17'd88200;
			4'h8: return 17'd96000;
			default: return 17'd96096;
		endcase
	endfunction

	// Rate written into the file for a selected code
	function automatic logic [16:0] stamp_hz(input logic [3:0] c);
		case (c)
			4'h3, 4'h6: return 17'd48000;
			4'ha: return 17'd96000;
			default: return run_hz(c);
		endcase
	endfunction

	// Closest internally generated rate to an external rate
	function automatic logic [16:0] nearest_hz(input logic [16:0] hz);
		logic [16:0] best;
		logic [16:0] bd;
		logic [16:0] cand;
		logic [16:0] d;
		best = run_hz(4'h0);
		bd = 17'h1ffff;
		for (int c = 0; c < 10; c++) begin
			cand = run_hz(4'(c));
			d = (cand > hz) ? cand - hz : hz - cand;
			if (d < bd) begin
				bd = d;
				best = cand;
			end
		end
		return best;
	endfunction

	// ----------------------------------------------------------------
	// Registers and synchronisers
	// ----------------------------------------------------------------
	logic [31:0] ctrl_r; // Links, limiter modes, word length, rate
	tmgl_gain_t [3:0] gain_r; // Master gains, tenths of a dB
	logic [23:0] lim_th_r; // Shared limiter threshold
	logic [1:0] att_sync_r; // Fader attach pin synchroniser
	logic [1:0] lock_sync_r; // External lock pin synchroniser
	logic attached; // Synchronised attach level
	logic ext_lock; // Synchronised lock level
	logic wb_req; // A bus cycle awaiting its answer
	logic wb_wr; // Write taken this cycle
	logic [3:0] lim_act_r; // Limiter reducing gain, per track
	tmgl_lim_t [1:0] lim_mode; // Mode per pair

	assign attached = att_sync_r[1];
	assign ext_lock = lock_sync_r[1];
	assign wb_req = cyc_i && stb_i && !ack_o;
	assign wb_wr = wb_req && we_i;
	assign lim_mode[0] = tmgl_lim_t'(ctrl_r[`TMGL_CTRL_LIM_LR]);
	assign lim_mode[1] = tmgl_lim_t'(ctrl_r[`TMGL_CTRL_LIM_AUX]);

	// Pins pass two flops before any logic sees them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			att_sync_r <= 2'h0;
			lock_sync_r <= 2'h0;
		end else begin
			att_sync_r <= {att_sync_r[0], fader_attached_i};
			lock_sync_r <= {lock_sync_r[0], ext_lock_i};
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Ack one cycle after the request; dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= wb_req;
		end
	end

	// Read mux; unmapped offsets answer with zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (wb_req && !we_i) begin
			case (adr_i)
				`TMGL_ADR_CTRL: dat_o <= ctrl_r;
				`TMGL_ADR_LIMTH: dat_o <= {8'h0, lim_th_r};
				// Limiter indicators and external lock
				`TMGL_ADR_STAT: begin
					dat_o <= {20'h0, ext_lock, attached,
						lim_mode[1] == TMGL_LIM_LINKED,
						lim_mode[0] == TMGL_LIM_LINKED,
						lim_mode[1] != TMGL_LIM_OFF,
						lim_mode[1] != TMGL_LIM_OFF,
						lim_mode[0] != TMGL_LIM_OFF,
						lim_mode[0] != TMGL_LIM_OFF,
						lim_act_r};
				end
				`TMGL_ADR_RATE: dat_o <= {15'h0, stamp_rate_hz_o};
				default: begin
					if (adr_i >= `TMGL_ADR_GAIN0 &&
						adr_i <= `TMGL_ADR_GAIN3 && adr_i[1:0] == 2'h0) begin
						dat_o <= 32'(signed'(gain_r[2'(adr_i[7:2] - 6'h1)]));
					end else begin
						dat_o <= 32'h0;
					end
				end
			endcase
		end
	end

	// Control and threshold registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `TMGL_CTRL_RST;
			lim_th_r <= `TMGL_LIM_TH_RST;
		end else if (wb_wr && adr_i == `TMGL_ADR_CTRL) begin
			ctrl_r <= wmerge(ctrl_r, dat_i, sel_i) & 32'h0000_0fff;
		end else if (wb_wr && adr_i == `TMGL_ADR_LIMTH) begin
			lim_th_r <= 24'(wmerge({8'h0, lim_th_r}, dat_i, sel_i));
		end
	end

	// ----------------------------------------------------------------
	// Master gains
	// ----------------------------------------------------------------
	// Sources: fader controller when attached, otherwise bus writes and
	// the knob register; a linked pair mirrors every change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				gain_r[i] <= `TMGL_GAIN_UNITY;
			end
		end else if (attached) begin
			for (int i = 0; i < 4; i++) begin
				// A linked pair follows the fader of its first track
				gain_r[i] <= gclamp(13'(fader_i.gain[ctrl_r[i >> 1] ?
					(i & 2) : i]));
			end
		end else if (wb_wr && sel_i[0]) begin
			for (int i = 0; i < 4; i++) begin
				logic lk;
				logic hit;
				lk = ctrl_r[i >> 1];
				if (adr_i == `TMGL_ADR_KNOB) begin
					hit = dat_i[`TMGL_KNOB_TRK] == 2'(i) ||
						(lk && dat_i[`TMGL_KNOB_TRK] == 2'(i ^ 1));
					if (hit && dat_i[`TMGL_KNOB_PRESS]) begin
						gain_r[i] <= `TMGL_GAIN_UNITY;
					end else if (hit) begin
						// One count of the knob is one tenth of a dB
						gain_r[i] <= gclamp(13'(signed'(gain_r[i])) +
							13'(signed'(dat_i[`TMGL_KNOB_STEP])));
					end
				end else begin
					hit = adr_i == 8'(`TMGL_ADR_GAIN0 + 4 * i) ||
						(lk && adr_i == 8'(`TMGL_ADR_GAIN0 + 4 * (i ^ 1)));
					if (hit) begin
						gain_r[i] <= gclamp(13'(signed'(dat_i[10:0])));
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Sample pipeline: gain, limiter, word length
	// ----------------------------------------------------------------
	tmgl_frame_t gain_fr_r; // After master gain
	tmgl_frame_t lim_fr_r; // After limiter
	logic [15:0] gr_r [4]; // Limiter gain, Q15, unity is full scale
	logic [23:0] lfsr_r; // Dither source

	// Master gain on the summed signal of each track
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gain_fr_r <= '0;
		end else begin
			gain_fr_r.valid <= frame_i.valid;
			if (frame_i.valid) begin
				for (int i = 0; i < 4; i++) begin
					gain_fr_r.smp[i] <= gapply(frame_i.smp[i], gain_r[i]);
				end
			end
		end
	end

	// Overload detect per track against the shared threshold
	logic [3:0] over;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			logic [23:0] mag;
			mag = gain_fr_r.smp[i][23] ? 24'(-gain_fr_r.smp[i])
				: 24'(gain_fr_r.smp[i]);
			over[i] = mag > lim_th_r;
		end
	end

	// Limiter: reduce quickly on overload, release slowly; linked pairs
	// share the deeper reduction so the stereo image does not shift
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				gr_r[i] <= `TMGL_GR_UNITY;
			end
		end else if (gain_fr_r.valid) begin
			for (int i = 0; i < 4; i++) begin
				logic [15:0] base;
				logic ov;
				base = gr_r[i];
				ov = over[i];
				if (lim_mode[i >> 1] == TMGL_LIM_LINKED) begin
					base = (gr_r[i ^ 1] < gr_r[i]) ? gr_r[i ^ 1] : gr_r[i];
					ov = over[i] | over[i ^ 1];
				end
				if (lim_mode[i >> 1] == TMGL_LIM_OFF) begin
					gr_r[i] <= `TMGL_GR_UNITY;
				end else if (ov) begin
					gr_r[i] <= base - (base >> 3);
				end else if (base < `TMGL_GR_UNITY - `TMGL_GR_REL) begin
					gr_r[i] <= base + `TMGL_GR_REL;
				end else begin
					gr_r[i] <= `TMGL_GR_UNITY;
				end
			end
		end
	end

	// Apply limiter gain, then hard clip at threshold as a backstop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lim_fr_r <= '0;
			lim_act_r <= 4'h0;
		end else begin
			lim_fr_r.valid <= gain_fr_r.valid;
			for (int i = 0; i < 4; i++) begin
				lim_act_r[i] <= lim_mode[i >> 1] != TMGL_LIM_OFF &&
					(gr_r[i] != `TMGL_GR_UNITY || over[i]);
			end
			if (gain_fr_r.valid) begin
				for (int i = 0; i < 4; i++) begin
					logic signed [47:0] v;
					logic signed [47:0] th;
					th = 48'(signed'({1'b0, lim_th_r}));
					v = (48'(gain_fr_r.smp[i]) *
						48'(signed'({1'b0, gr_r[i]}))) >>> 15;
					if (lim_mode[i >> 1] != TMGL_LIM_OFF) begin
						if (v > th) begin
							v = th;
						end else if (v < -th) begin
							v = -th;
						end
					end else begin
						v = 48'(gain_fr_r.smp[i]);
					end
					lim_fr_r.smp[i] <= sat24(v);
				end
			end
		end
	end

	// Free-running dither source, stepped once per sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfsr_r <= `TMGL_LFSR_SEED;
		end else if (lim_fr_r.valid) begin
			lfsr_r <= {lfsr_r[22:0],
				lfsr_r[23] ^ lfsr_r[22] ^ lfsr_r[21] ^ lfsr_r[16]};
		end
	end

	// Word-length reduction; 16-bit words leave the low byte zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_o <= '0;
		end else begin
			frame_o.valid <= lim_fr_r.valid;
			if (lim_fr_r.valid) begin
				for (int i = 0; i < 4; i++) begin
					tmgl_smp_t d;
					d = lim_fr_r.smp[i];
					if (!ctrl_r[`TMGL_CTRL_W16]) begin
						frame_o.smp[i] <= d;
					end else if (!ctrl_r[`TMGL_CTRL_DOFF]) begin
						// Noise added below the kept bits, then cut
						d = sat24(48'(d) + 48'(lfsr_r[i*4 +: 8]));
						frame_o.smp[i] <= {d[23:8], 8'h00};
					end else begin
						frame_o.smp[i] <= {d[23:8], 8'h00};
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Sample rate, file stamp and high-rate restrictions
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_rate_hz_o <= 17'h0;
			stamp_rate_hz_o <= 17'h0;
			restrict_o <= '0;
		end else begin
			if (ext_lock) begin
				run_rate_hz_o <= ext_rate_hz_i;
				stamp_rate_hz_o <= nearest_hz(ext_rate_hz_i);
			end else begin
				run_rate_hz_o <= run_hz(ctrl_r[`TMGL_CTRL_RATE]);
				stamp_rate_hz_o <= stamp_hz(ctrl_r[`TMGL_CTRL_RATE]);
			end
			// Judged on the rate actually running, one cycle behind
			if (run_rate_hz_o > `TMGL_HIGH_HZ) begin
				restrict_o <= {1'b1, `TMGL_HI_TRACKS, `TMGL_HI_MEDIA,
					`TMGL_HI_DELAY_MS, 1'b0, 1'b0};
			end else begin
				restrict_o <= {1'b0, 4'h0, 2'h0, 5'h0, 1'b1, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/tmgl_stage_asserts.sv ====
// Port assertions for the track gain and limiter stage
`timescale 1ns/1ps
`default_nettype none
module tmgl_stage_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sample path
	input wire tmgl_pkg::tmgl_frame_t frame_i,
	input wire tmgl_pkg::tmgl_frame_t frame_o,
	// Rates and restrictions
	input wire logic [16:0] run_rate_hz_o,
	input wire logic [16:0] stamp_rate_hz_o,
	input wire tmgl_pkg::tmgl_restrict_t restrict_o
);
	import tmgl_pkg::*;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Sample path timing
	// ----------------------------------------
	AST_LATENCY: assert property (
		frame_i.valid |-> ##3 frame_o.valid)
		else $error("output frame late or missing");
	AST_NO_EXTRA: assert property (
		frame_o.valid |-> $past(frame_i.valid, 3))
		else $error("output frame without an input frame");
	// Reset clears the samples, so the cycle after it is skipped
	AST_HOLD: assert property (
		!frame_o.valid && !$past(rst_i) |-> $stable(frame_o.smp))
		else $error("output samples moved between frames");
	// ----------------------------------------
	// Rates, stamps and restrictions
	// ----------------------------------------
	AST_HIGH_RATE: assert property (
		run_rate_hz_o > 17'h0bbb0 |=>
		restrict_o == {1'b1, 4'h8, 2'h2, 5'h0f, 2'b00})
		else $error("high rate restrictions wrong");
	AST_LOW_RATE: assert property (
		run_rate_hz_o != 17'h0 && run_rate_hz_o <= 17'h0bbb0 |=>
		restrict_o == {1'b0, 4'h0, 2'h0, 5'h00, 2'b11})
		else $error("standard rate restrictions wrong");
	AST_STAMP_SET: assert property (
		run_rate_hz_o != 17'h0 |-> stamp_rate_hz_o inside {17'h07d00,
		17'h0ac44, 17'h0bb50, 17'h0bb80, 17'h0bbb0, 17'h15888,
		17'h17700, 17'h17760})
		else $error("stamp is not a generated rate");
	AST_PULL48: assert property (
		run_rate_hz_o inside {17'h0bb50, 17'h0bbb0} |->
		stamp_rate_hz_o == run_rate_hz_o || stamp_rate_hz_o == 17'h0bb80)
		else $error("pulled 48k stamp wrong");
	AST_PULL96: assert property (
		run_rate_hz_o == 17'h17760 |->
		stamp_rate_hz_o inside {17'h17760, 17'h17700})
		else $error("pulled 96k stamp wrong");
endmodule
bind tmgl_stage tmgl_stage_chk u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.frame_i(frame_i),
	.frame_o(frame_o),
	.run_rate_hz_o(run_rate_hz_o),
	.stamp_rate_hz_o(stamp_rate_hz_o),
	.restrict_o(restrict_o)
);
`default_nettype wire

// ==== sim/tmgl_feeder.sv ====
// Upstream summing model: one summed frame per request
`timescale 1ns/1ps
`default_nettype none
module tmgl_feeder (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Request from the bench
	input wire logic send_i,
	input wire tmgl_pkg::tmgl_smp_t [3:0] smp_i,
	// Frame towards the stage
	output tmgl_pkg::tmgl_frame_t frame_o
);
	import tmgl_pkg::*;
	// Strobe lasts one cycle; samples are scrambled between frames
	// so the stage cannot lean on stale data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_o <= '0;
		end else if (send_i) begin
			frame_o <= {1'b1, smp_i};
		end else begin
			frame_o <= {1'b0, ~frame_o.smp};
		end
	end
endmodule
`default_nettype wire

// ==== sim/tmgl_stage_tb_top.sv ====
// Self-checking bench for the track gain and limiter stage
`timescale 1ns/1ps
`default_nettype none
`include "tmgl_map.svh"
module tmgl_stage_tb_top;
	import tmgl_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack, send = 1'b0, att = 1'b0, lock = 1'b0;
	logic [16:0] erate = 17'h0, run, stamp;
	tmgl_frame_t fi, fo;
	tmgl_fader_t fad = '0;
	tmgl_restrict_t rs;
	tmgl_smp_t [3:0] sv = '0, so;
	int fail_count = 0, checks = 0;
	// Run and stamp per rate code
	logic [16:0] rnt [11] = '{17'h07d00, 17'h0ac44, 17'h0bb50, 17'h0bb50,
		17'h0bb80, 17'h0bbb0, 17'h0bbb0, 17'h15888, 17'h17700, 17'h17760,
		17'h17760};
	logic [16:0] stt [11] = '{17'h07d00, 17'h0ac44, 17'h0bb50, 17'h0bb80,
		17'h0bb80, 17'h0bbb0, 17'h0bb80, 17'h15888, 17'h17700, 17'h17760,
		17'h17700};
	always #2.5 clk = ~clk;
	tmgl_feeder feeder (.clk_i(clk), .rst_i(rst), .send_i(send),
		.smp_i(sv), .frame_o(fi));
	tmgl_stage dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .frame_i(fi), .frame_o(fo), .fader_attached_i(att),
		.fader_i(fad), .ext_lock_i(lock), .ext_rate_hz_i(erate),
		.run_rate_hz_o(run), .stamp_rate_hz_o(stamp), .restrict_o(rs));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request held until ack is sampled; one idle cycle follows;
	// a slave that never answers is left to the watchdog
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	// Left and right through the feeder, aux tracks silent
	task automatic frame(input tmgl_smp_t l, input tmgl_smp_t r);
		sv <= {24'sh0, 24'sh0, r, l};
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		do begin
			@(posedge clk);
		end while (fo.valid !== 1'b1);
		so = fo.smp;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdc(`TMGL_ADR_CTRL, 32'h400);
		rdc(`TMGL_ADR_GAIN0, 32'h0);
		rdc(`TMGL_ADR_LIMTH, 32'h7a0000);
		rdc(8'h40, 32'h0);
		rdc(`TMGL_ADR_RATE, 32'hbb80);
	endtask
	// Clamping, knob steps and press, pair linking
	task automatic t_gain();
		wb(1'b1, `TMGL_ADR_GAIN0, 32'h0000_00c8);
		rdc(`TMGL_ADR_GAIN0, 32'h0000_0096);
		wb(1'b1, `TMGL_ADR_GAIN0, 32'hffff_fd44);
		rdc(`TMGL_ADR_GAIN0, 32'hffff_fda8);
		wb(1'b1, `TMGL_ADR_KNOB, 32'h0000_00ff);
		rdc(`TMGL_ADR_GAIN0, 32'hffff_fda8);
		wb(1'b1, `TMGL_ADR_KNOB, 32'h0000_0400);
		rdc(`TMGL_ADR_GAIN0, 32'h0);
		wb(1'b1, `TMGL_ADR_KNOB, 32'h0000_0305);
		rdc(`TMGL_ADR_GAIN3, 32'h5);
		rdc(8'h0c, 32'h0);
		wb(1'b1, `TMGL_ADR_GAIN3, 32'h0);
		wb(1'b1, `TMGL_ADR_CTRL, 32'h401);
		wb(1'b1, `TMGL_ADR_GAIN0, 32'h1e);
		rdc(8'h08, 32'h1e);
		wb(1'b1, `TMGL_ADR_KNOB, 32'h0000_0102);
		rdc(`TMGL_ADR_GAIN0, 32'h20);
		wb(1'b1, `TMGL_ADR_GAIN0, 32'h0);
	endtask
	// Unity pass, attenuation, truncation and dither
	task automatic t_path();
		logic up, dn;
		up = 1'b0;
		dn = 1'b0;
		wb(1'b1, `TMGL_ADR_CTRL, 32'h400);
		frame(24'sh123456, 24'shedcbaa);
		check({8'h0, so[0]}, 32'h123456);
		check({8'h0, so[1]}, 32'hedcbaa);
		wb(1'b1, `TMGL_ADR_GAIN0, 32'hffff_fda8);
		frame(24'sh400000, 24'sh400000);
		check({31'h0, so[0] < 24'sh002000}, 32'h1);
		check({8'h0, so[1]}, 32'h400000);
		wb(1'b1, `TMGL_ADR_GAIN0, 32'h0);
		wb(1'b1, `TMGL_ADR_CTRL, 32'h4c0);
		frame(24'sh123456, 24'shedcbaa);
		check({8'h0, so[0]}, 32'h123400);
		check({8'h0, so[1]}, 32'hedcb00);
		// Half-step input: dither must round both ways over a run
		wb(1'b1, `TMGL_ADR_CTRL, 32'h440);
		repeat (16) begin
			frame(24'sh123480, 24'sh0);
			check({9'h0, so[0][23:9], so[0][7:0]}, 32'h91a00);
			up |= so[0][23:8] == 16'h1235;
			dn |= so[0][23:8] == 16'h1234;
		end
		check({30'h0, up, dn}, 32'h3);
	endtask
	// Independent then linked, aux pair in the spare mode code
	task automatic t_lim();
		wb(1'b1, `TMGL_ADR_LIMTH, 32'h100000);
		wb(1'b1, `TMGL_ADR_CTRL, 32'h404);
		repeat (4) frame(24'sh400000, 24'sh010000);
		check({8'h0, so[0]}, 32'h100000);
		check({8'h0, so[1]}, 32'h010000);
		rdc(`TMGL_ADR_STAT, 32'h31);
		wb(1'b1, `TMGL_ADR_CTRL, 32'h438);
		repeat (4) frame(24'sh400000, 24'sh010000);
		check({31'h0, so[1] < 24'sh010000}, 32'h1);
		rdc(`TMGL_ADR_STAT, 32'h1f3);
	endtask
	// Attached controller owns the gains; bus writes are ignored
	task automatic t_fader();
		fad <= 44'h0000_0001_979c;
		att <= 1'b1;
		repeat (6) @(posedge clk);
		rdc(`TMGL_ADR_GAIN0, 32'hffff_ff9c);
		rdc(8'h08, 32'h32);
		// Linking is still set locally and joins the pair's faders
		wb(1'b1, `TMGL_ADR_CTRL, 32'h401);
		rdc(8'h08, 32'hffff_ff9c);
		wb(1'b1, `TMGL_ADR_GAIN0, 32'h32);
		rdc(`TMGL_ADR_GAIN0, 32'hffff_ff9c);
		att <= 1'b0;
	endtask
	// Every rate code, then an off-speed external clock
	task automatic t_rate();
		for (int i = 0; i < 11; i++) begin
			wb(1'b1, `TMGL_ADR_CTRL, {20'h0, 4'(i), 8'h00});
			repeat (3) @(posedge clk);
			rdc(`TMGL_ADR_RATE, {15'h0, stt[i]});
			check({15'h0, run}, {15'h0, rnt[i]});
			check({28'h0, rs.max_tracks}, rnt[i] > 17'h0bbb0 ? 32'h8 : 32'h0);
		end
		erate <= 17'h0b798;
		lock <= 1'b1;
		repeat (6) @(posedge clk);
		rdc(`TMGL_ADR_RATE, 32'hbb50);
		check({15'h0, run}, 32'hb798);
	endtask
	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_gain();
		t_path();
		t_lim();
		t_fader();
		t_rate();
		results();
	end
	// Whole run needs a few hundred cycles; this is far beyond it
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
